// File: rtl/aics_channel_select.sv
// converter positive-input channel select with sensor enable and offset bytes
//
// Function
// R1 - upper three select bits read zero, ignore writes
// R2 - low five bits hold read/write input code
// R3 - decode code to pins, sensor, supplies, ground
// R4 - software grounds input before choosing sensor
// R5 - sensor enable bit gates sensor, else high-z
// R6 - sensor code routes sensor to positive input
// R7 - read-only factory offset for sensor exposed
// R8 - software calibrates offset, stores in flash
// R9 - offset split high 9:2, low 1:0 top
// R10 - write updates mux at once, conversion undisturbed; sensor drive follows the live mux, so a write cuts it mid-conversion
`timescale 1ns/100ps
module aics_channel_select #(
  parameter logic [9:0] OFFSET_VALUE = aics_pkg::OFFSET_DEFAULT  // factory trim, arbitrary default
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input aics_pkg::aics_sfr_t sfr_i,
  input wire logic conv_busy_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_rvalid_o,
  output aics_pkg::aics_sel_t mux_sel_o,
  output aics_pkg::aics_sel_t sample_sel_o,
  output logic temp_sensor_on_o,
  output logic temp_sensor_drive_o
);
  // ****************************************
  // state
  // ****************************************
  logic [4:0] positive_input_code_ff;      // the input code
  logic [4:0] nxt_positive_input_code;
  logic [7:0] reference_control_reg_ff;    // reference control, holds sensor enable
  logic [7:0] nxt_reference_control_reg;
  logic [7:0] rdata_ff;                    // registered read data
  logic [7:0] nxt_rdata;
  logic rvalid_ff;                         // read answer strobe
  logic nxt_rvalid;
  aics_pkg::aics_sel_t mux_sel_ff;         // live mux steering
  aics_pkg::aics_sel_t nxt_mux_sel;        // steering for the next edge
  aics_pkg::aics_sel_t sample_sel_ff;      // steering held for a running conversion
  aics_pkg::aics_sel_t nxt_sample_sel;
  aics_pkg::aics_sel_t dec_sel;            // decode of the next code
  logic drive_ff;                          // sensor drives its output
  logic nxt_drive;
  logic hit_main;                          // access on the main page
  logic hit_cal;                           // access on the calibration page

  // decode the next code so the mux moves on the write edge itself
  aics_decode u_decode (
    .code_i(nxt_positive_input_code),
    .sel_o(dec_sel)
  );

  // ****************************************
  // register writes and reads
  // ****************************************
  // the offset is wired from a parameter, so writes to it simply fall away
  always_comb begin
    hit_main = (sfr_i.page == aics_pkg::PAGE_MAIN);
    hit_cal = (sfr_i.page == aics_pkg::PAGE_CAL);
    nxt_positive_input_code = positive_input_code_ff;
    nxt_reference_control_reg = reference_control_reg_ff;
    nxt_rdata = rdata_ff;
    nxt_rvalid = 1'b0;
    if (sfr_i.wr && hit_main) begin
      if (sfr_i.addr == aics_pkg::INPUT_SELECT_ADDR) begin
        nxt_positive_input_code = sfr_i.wdata[aics_pkg::CODE_MSB:0];  // [R1] [R2] [R10]
      end else if (sfr_i.addr == aics_pkg::REF_CONTROL_ADDR) begin
        nxt_reference_control_reg = sfr_i.wdata & aics_pkg::REF_CONTROL_MASK;
      end
    end
    if (sfr_i.rd) begin
      nxt_rvalid = 1'b1;
      nxt_rdata = 8'h00;  // unmapped reads give zero
      if (hit_main && sfr_i.addr == aics_pkg::INPUT_SELECT_ADDR) begin
        nxt_rdata = {3'h0, positive_input_code_ff};  // [R1] [R2]
      end else if (hit_main && sfr_i.addr == aics_pkg::REF_CONTROL_ADDR) begin
        nxt_rdata = reference_control_reg_ff;
      end else if (hit_cal && sfr_i.addr == aics_pkg::OFFSET_HIGH_ADDR) begin
        nxt_rdata = OFFSET_VALUE[9:2];  // [R7] [R9]
      end else if (hit_cal && sfr_i.addr == aics_pkg::OFFSET_LOW_ADDR) begin
        nxt_rdata = {OFFSET_VALUE[1:0], 6'h00};  // [R7] [R9]
      end
    end
  end

  // ****************************************
  // mux and sensor control
  // ****************************************
  // sampling steering only follows while idle, so a conversion keeps its channel
  always_comb begin
    nxt_mux_sel = dec_sel;  // [R10]
    nxt_sample_sel = sample_sel_ff;
    if (!conv_busy_i) begin
      nxt_sample_sel = dec_sel;  // [R10]
    end
    // the sensor output stays high impedance unless enabled and selected
    nxt_drive = nxt_reference_control_reg[aics_pkg::SENSOR_ON_BIT]
                && (dec_sel.kind == aics_pkg::SRC_TEMP);  // [R5] [R6]
  end

  // bus-side registers only; sync reset puts the code on ground
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      positive_input_code_ff <= aics_pkg::CODE_RESET;
      reference_control_reg_ff <= aics_pkg::REF_CONTROL_RESET;
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      positive_input_code_ff <= nxt_positive_input_code;
      reference_control_reg_ff <= nxt_reference_control_reg;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // mux-side registers only; reset steering matches the ground reset code
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      mux_sel_ff <= '{kind: aics_pkg::SRC_GROUND, port: 2'h0, pin: 3'h0};
      sample_sel_ff <= '{kind: aics_pkg::SRC_GROUND, port: 2'h0, pin: 3'h0};
      drive_ff <= 1'b0;  // sensor high impedance out of reset
    end else begin
      mux_sel_ff <= nxt_mux_sel;
      sample_sel_ff <= nxt_sample_sel;
      drive_ff <= nxt_drive;
    end
  end

  assign sfr_rdata_o = rdata_ff;
  assign sfr_rvalid_o = rvalid_ff;
  assign mux_sel_o = mux_sel_ff;
  assign sample_sel_o = sample_sel_ff;
  assign temp_sensor_on_o = reference_control_reg_ff[aics_pkg::SENSOR_ON_BIT];
  assign temp_sensor_drive_o = drive_ff;

  // ****************************************
  // checks
  // ****************************************
  a_upper_bits_zero: assert property (@(posedge clock_i) disable iff (reset_i)  // [R1]
    $past(sfr_i.rd) && $past(sfr_i.page) == aics_pkg::PAGE_MAIN
    && $past(sfr_i.addr) == aics_pkg::INPUT_SELECT_ADDR |-> sfr_rdata_o[7:5] == 3'h0)
    else $error("select upper bits not zero");
  a_code_write_back: assert property (@(posedge clock_i) disable iff (reset_i)  // [R2]
    sfr_i.wr && sfr_i.page == aics_pkg::PAGE_MAIN && sfr_i.addr == aics_pkg::INPUT_SELECT_ADDR
    |=> positive_input_code_ff == $past(sfr_i.wdata[4:0]))
    else $error("code write lost");
  a_ground_decode: assert property (@(posedge clock_i) disable iff (reset_i)  // [R3]
    positive_input_code_ff == aics_pkg::CODE_GROUND |-> mux_sel_o.kind == aics_pkg::SRC_GROUND)
    else $error("ground code not decoded");
  a_sensor_gated: assert property (@(posedge clock_i) disable iff (reset_i)  // [R5]
    temp_sensor_drive_o |-> temp_sensor_on_o)
    else $error("sensor drives while off");
  a_sensor_routed: assert property (@(posedge clock_i) disable iff (reset_i)  // [R6]
    temp_sensor_drive_o |-> mux_sel_o.kind == aics_pkg::SRC_TEMP)
    else $error("sensor drives when not selected");
  a_offset_low: assert property (@(posedge clock_i) disable iff (reset_i)  // [R7] [R9]
    sfr_i.rd && sfr_i.page == aics_pkg::PAGE_CAL && sfr_i.addr == aics_pkg::OFFSET_LOW_ADDR
    |=> sfr_rdata_o == {OFFSET_VALUE[1:0], 6'h00})
    else $error("offset low byte wrong");
  a_offset_high: assert property (@(posedge clock_i) disable iff (reset_i)  // [R9]
    sfr_i.rd && sfr_i.page == aics_pkg::PAGE_CAL && sfr_i.addr == aics_pkg::OFFSET_HIGH_ADDR
    |=> sfr_rdata_o == OFFSET_VALUE[9:2])
    else $error("offset high byte wrong");
  a_busy_holds: assert property (@(posedge clock_i) disable iff (reset_i)  // [R10]
    conv_busy_i |=> $stable(sample_sel_o))
    else $error("sample channel moved during conversion");
  a_mux_follows: assert property (@(posedge clock_i) disable iff (reset_i)  // [R10]
    sfr_i.wr && sfr_i.page == aics_pkg::PAGE_MAIN && sfr_i.addr == aics_pkg::INPUT_SELECT_ADDR
    && sfr_i.wdata[4:0] == aics_pkg::CODE_GROUND |=> mux_sel_o.kind == aics_pkg::SRC_GROUND)
    else $error("mux not updated on write");
  a_rvalid_after_read: assert property (@(posedge clock_i) disable iff (reset_i)  // [R2]
    sfr_rvalid_o |-> $past(sfr_i.rd))
    else $error("read answer without request");
  a_read_gets_answer: assert property (@(posedge clock_i) disable iff (reset_i)  // [R2]
    sfr_i.rd |=> sfr_rvalid_o)
    else $error("read request not answered");
  a_code_readback: assert property (@(posedge clock_i) disable iff (reset_i)  // [R2]
    sfr_i.rd && sfr_i.page == aics_pkg::PAGE_MAIN && sfr_i.addr == aics_pkg::INPUT_SELECT_ADDR
    |=> sfr_rdata_o == {3'h0, $past(positive_input_code_ff)})
    else $error("code read back wrong");

  // ****************************************
  // decode checks
  // ****************************************
  // steering and code register move on the same edge, so they are compared directly
  a_port0_decode: assert property (@(posedge clock_i) disable iff (reset_i)  // [R3]
    positive_input_code_ff <= aics_pkg::CODE_P0_LAST |-> mux_sel_o.kind == aics_pkg::SRC_PORT
    && mux_sel_o.port == 2'h0 && mux_sel_o.pin == positive_input_code_ff[2:0])
    else $error("port 0 code decoded wrong");
  a_port1_decode: assert property (@(posedge clock_i) disable iff (reset_i)  // [R3]
    positive_input_code_ff >= aics_pkg::CODE_P1_FIRST && positive_input_code_ff <= aics_pkg::CODE_P1_LAST
    |-> mux_sel_o.kind == aics_pkg::SRC_PORT && mux_sel_o.port == 2'h1 && mux_sel_o.pin == positive_input_code_ff[2:0])
    else $error("port 1 code decoded wrong");
  a_port2_decode: assert property (@(posedge clock_i) disable iff (reset_i)  // [R3]
    positive_input_code_ff >= aics_pkg::CODE_P2_FIRST && positive_input_code_ff <= aics_pkg::CODE_P2_LAST
    |-> mux_sel_o.kind == aics_pkg::SRC_PORT && mux_sel_o.port == 2'h2 && mux_sel_o.pin == positive_input_code_ff[2:0])
    else $error("port 2 code decoded wrong");
  a_temp_decode: assert property (@(posedge clock_i) disable iff (reset_i)  // [R6]
    positive_input_code_ff == aics_pkg::CODE_TEMP |-> mux_sel_o.kind == aics_pkg::SRC_TEMP)
    else $error("sensor code not decoded");
  a_supply_decode: assert property (@(posedge clock_i) disable iff (reset_i)  // [R3]
    positive_input_code_ff == aics_pkg::CODE_SUPPLY_A || positive_input_code_ff == aics_pkg::CODE_SUPPLY_B
    |-> mux_sel_o.kind == aics_pkg::SRC_SUPPLY)
    else $error("supply code not decoded");
  a_regulator_decode: assert property (@(posedge clock_i) disable iff (reset_i)  // [R3]
    positive_input_code_ff == aics_pkg::CODE_REGULATOR |-> mux_sel_o.kind == aics_pkg::SRC_REGULATOR)
    else $error("regulator code not decoded");
  // reserved codes must leave the mux open so no stray source is connected
  a_reserved_open: assert property (@(posedge clock_i) disable iff (reset_i)  // [R3]
    (positive_input_code_ff > aics_pkg::CODE_P0_LAST && positive_input_code_ff < aics_pkg::CODE_P1_FIRST)
    || (positive_input_code_ff > aics_pkg::CODE_P2_LAST && positive_input_code_ff < aics_pkg::CODE_TEMP)
    |-> mux_sel_o.kind == aics_pkg::SRC_NONE)
    else $error("reserved code not left open");
  a_sensor_enabled: assert property (@(posedge clock_i) disable iff (reset_i)  // [R5]
    temp_sensor_on_o && mux_sel_o.kind == aics_pkg::SRC_TEMP |-> temp_sensor_drive_o)
    else $error("enabled sensor not driving");
  a_sample_follows: assert property (@(posedge clock_i) disable iff (reset_i)  // [R10]
    !conv_busy_i |=> sample_sel_o == mux_sel_o)
    else $error("sample channel not following while idle");
endmodule

// File: rtl/aics_decode.sv
// combinational decoder from input code to mux steering
`timescale 1ns/100ps
module aics_decode (
  input wire logic [4:0] code_i,
  output aics_pkg::aics_sel_t sel_o
);
  // ****************************************
  // code to source map
  // ****************************************
  // reserved codes leave the mux open rather than guessing a source
  always_comb begin
    sel_o = '{kind: aics_pkg::SRC_NONE, port: 2'h0, pin: 3'h0};
    if (code_i <= aics_pkg::CODE_P0_LAST) begin  // [R3]
      sel_o = '{kind: aics_pkg::SRC_PORT, port: 2'h0, pin: code_i[2:0]};
    end else if (code_i >= aics_pkg::CODE_P1_FIRST && code_i <= aics_pkg::CODE_P1_LAST) begin  // [R3]
      sel_o = '{kind: aics_pkg::SRC_PORT, port: 2'h1, pin: code_i[2:0]};
    end else if (code_i >= aics_pkg::CODE_P2_FIRST && code_i <= aics_pkg::CODE_P2_LAST) begin  // [R3]
      sel_o = '{kind: aics_pkg::SRC_PORT, port: 2'h2, pin: code_i[2:0]};
    end else if (code_i == aics_pkg::CODE_TEMP) begin  // [R6]
      sel_o.kind = aics_pkg::SRC_TEMP;
    end else if (code_i == aics_pkg::CODE_SUPPLY_A || code_i == aics_pkg::CODE_SUPPLY_B) begin  // [R3]
      sel_o.kind = aics_pkg::SRC_SUPPLY;
    end else if (code_i == aics_pkg::CODE_REGULATOR) begin  // [R3]
      sel_o.kind = aics_pkg::SRC_REGULATOR;
    end else if (code_i == aics_pkg::CODE_GROUND) begin  // [R3]
      sel_o.kind = aics_pkg::SRC_GROUND;
    end
  end
endmodule

// File: rtl/aics_pkg.sv
// package for the converter input channel select block
package aics_pkg;

  // ****************************************
  // register addresses and layout
  // ****************************************
  localparam logic [7:0] INPUT_SELECT_ADDR = 8'hBB;   // channel select register
  localparam logic [7:0] OFFSET_HIGH_ADDR = 8'h86;    // sensor offset high byte
  localparam logic [7:0] OFFSET_LOW_ADDR = 8'h85;     // sensor offset low byte
  localparam logic [7:0] REF_CONTROL_ADDR = 8'hD1;    // reference control register
  localparam logic [3:0] PAGE_MAIN = 4'h0;            // page of select and reference
  localparam logic [3:0] PAGE_CAL = 4'hF;             // page of the offset bytes
  localparam int CODE_MSB = 4;                        // top bit of the input code
  localparam int SENSOR_ON_BIT = 2;                   // sensor enable in reference reg
  localparam logic [4:0] CODE_RESET = 5'h1F;          // selects ground after reset
  localparam logic [7:0] REF_CONTROL_RESET = 8'h18;   // reference reg reset value
  localparam logic [7:0] REF_CONTROL_MASK = 8'h3D;    // writable bits of reference reg
  localparam logic [9:0] OFFSET_DEFAULT = 10'h200;    // arbitrary neutral offset

  // ****************************************
  // input code values
  // ****************************************
  localparam logic [4:0] CODE_P0_LAST = 5'h07;
  localparam logic [4:0] CODE_P1_FIRST = 5'h0D;
  localparam logic [4:0] CODE_P1_LAST = 5'h0F;
  localparam logic [4:0] CODE_P2_FIRST = 5'h10;
  localparam logic [4:0] CODE_P2_LAST = 5'h16;
  localparam logic [4:0] CODE_TEMP = 5'h1B;
  localparam logic [4:0] CODE_SUPPLY_A = 5'h1C;
  localparam logic [4:0] CODE_REGULATOR = 5'h1D;
  localparam logic [4:0] CODE_SUPPLY_B = 5'h1E;
  localparam logic [4:0] CODE_GROUND = 5'h1F;

  // source kinds the analog mux can connect
  typedef enum logic [2:0] {
    SRC_PORT,
    SRC_TEMP,
    SRC_SUPPLY,
    SRC_REGULATOR,
    SRC_GROUND,
    SRC_NONE
  } aics_src_t;

  // decoded mux steering, one bundle
  typedef struct packed {
    aics_src_t kind;       // which class of source
    logic [1:0] port;      // port number for pin sources
    logic [2:0] pin;       // pin number for pin sources
  } aics_sel_t;

  // register access from the cpu special-function bus
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } aics_sfr_t;
endpackage

// File: tb/adc_input_channel_select_bench.sv
// self-checking bench for the converter input channel select block
`timescale 1ns/100ps
module adc_input_channel_select_bench;
  // ****************************************
  // signals and instance
  // ****************************************
  localparam logic [9:0] TRIM = 10'h2B7;  // factory trim for the bench, arbitrary value
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  aics_pkg::aics_sfr_t sfr_i = '0;
  logic conv_busy_i = 1'b0;
  logic [7:0] sfr_rdata_o;
  logic sfr_rvalid_o;
  aics_pkg::aics_sel_t mux_sel_o;
  aics_pkg::aics_sel_t sample_sel_o;
  logic temp_sensor_on_o;
  logic temp_sensor_drive_o;
  int errors = 0;      // mismatches seen
  int n_compared = 0;  // comparisons made
  int cycles = 0;      // timeout counter
  logic [7:0] rd_val;  // last value read back

  aics_channel_select #(.OFFSET_VALUE(TRIM)) dut_u (.clock_i(clock_i), .reset_i(reset_i), .sfr_i(sfr_i),
    .conv_busy_i(conv_busy_i), .sfr_rdata_o(sfr_rdata_o), .sfr_rvalid_o(sfr_rvalid_o), .mux_sel_o(mux_sel_o),
    .sample_sel_o(sample_sel_o), .temp_sensor_on_o(temp_sensor_on_o), .temp_sensor_drive_o(temp_sensor_drive_o));

  // 4 ns clock
  initial begin
    forever #2 clock_i = ~clock_i;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // the whole run takes under two hundred cycles, so 2000 means a hang
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errors = errors + 1;
      give_verdict();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("[FAIL] %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // pin sources compare port and pin too; others only by kind, their pin fields are free
  task automatic chk_sel(input aics_pkg::aics_sel_t seen, input aics_pkg::aics_sel_t exp, input string what);
    if (exp.kind == aics_pkg::SRC_PORT) chk(seen, exp, what);
    else chk({5'h00, seen.kind}, {5'h00, exp.kind}, what);
  endtask

  // expected steering for a code, worked out from the code table
  function automatic aics_pkg::aics_sel_t exp_sel(input logic [4:0] c);
    aics_pkg::aics_sel_t s;
    s = '{kind: aics_pkg::SRC_NONE, port: 2'h0, pin: c[2:0]};
    if (c <= 5'h07) s.kind = aics_pkg::SRC_PORT;
    else if (c >= 5'h0D && c <= 5'h0F) s = '{kind: aics_pkg::SRC_PORT, port: 2'h1, pin: c[2:0]};
    else if (c >= 5'h10 && c <= 5'h16) s = '{kind: aics_pkg::SRC_PORT, port: 2'h2, pin: c[2:0]};
    else if (c == 5'h1B) s.kind = aics_pkg::SRC_TEMP;
    else if (c == 5'h1C || c == 5'h1E) s.kind = aics_pkg::SRC_SUPPLY;
    else if (c == 5'h1D) s.kind = aics_pkg::SRC_REGULATOR;
    else if (c == 5'h1F) s.kind = aics_pkg::SRC_GROUND;
    return s;
  endfunction

  // one-cycle write strobe, taken at the next edge
  task automatic wr(input logic [3:0] pg, input logic [7:0] ad, input logic [7:0] d);
    @(posedge clock_i);
    sfr_i <= '{wr: 1'b1, rd: 1'b0, page: pg, addr: ad, wdata: d};
    @(posedge clock_i);
    sfr_i <= '0;
    #1;
  endtask

  // one-cycle read strobe, answer valid one cycle later
  task automatic rd(input logic [3:0] pg, input logic [7:0] ad);
    @(posedge clock_i);
    sfr_i <= '{wr: 1'b0, rd: 1'b1, page: pg, addr: ad, wdata: 8'h00};
    @(posedge clock_i);
    sfr_i <= '0;
    #1;
    chk({7'h00, sfr_rvalid_o}, 8'h01, "read valid");
    rd_val = sfr_rdata_o;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (8) @(posedge clock_i);
    reset_i <= 1'b0;
    rd(aics_pkg::PAGE_MAIN, aics_pkg::INPUT_SELECT_ADDR);
    chk(rd_val, 8'h1F, "select reset");
    chk_sel(mux_sel_o, exp_sel(5'h1F), "mux after reset");
    rd(aics_pkg::PAGE_MAIN, aics_pkg::REF_CONTROL_ADDR);
    chk(rd_val, 8'h18, "reference reset");
    chk({7'h00, temp_sensor_on_o}, 8'h00, "sensor off at reset");
    $display("test reset done");
    // upper bits written high must read zero, every code decoded
    for (int c = 0; c < 32; c++) begin
      if (c[4:0] == aics_pkg::CODE_TEMP) wr(aics_pkg::PAGE_MAIN, aics_pkg::INPUT_SELECT_ADDR, 8'h1F);
      wr(aics_pkg::PAGE_MAIN, aics_pkg::INPUT_SELECT_ADDR, {3'h7, c[4:0]});
      chk_sel(mux_sel_o, exp_sel(c[4:0]), "mux steering");
      chk_sel(sample_sel_o, exp_sel(c[4:0]), "sample steering");
      rd(aics_pkg::PAGE_MAIN, aics_pkg::INPUT_SELECT_ADDR);
      chk(rd_val, {3'h0, c[4:0]}, "select readback");
    end
    $display("test decode done");
    // ground first, then sensor, with the enable off and then on
    wr(aics_pkg::PAGE_MAIN, aics_pkg::INPUT_SELECT_ADDR, 8'h1F);
    wr(aics_pkg::PAGE_MAIN, aics_pkg::INPUT_SELECT_ADDR, 8'h1B);
    @(posedge clock_i);
    #1;
    chk({7'h00, temp_sensor_drive_o}, 8'h00, "sensor high-z while off");
    wr(aics_pkg::PAGE_MAIN, aics_pkg::REF_CONTROL_ADDR, 8'hFF);
    @(posedge clock_i);
    #1;
    chk({7'h00, temp_sensor_on_o}, 8'h01, "sensor on");
    chk({7'h00, temp_sensor_drive_o}, 8'h01, "sensor drives input");
    rd(aics_pkg::PAGE_MAIN, aics_pkg::REF_CONTROL_ADDR);
    chk(rd_val, 8'h3D, "reference writable bits");
    wr(aics_pkg::PAGE_MAIN, aics_pkg::REF_CONTROL_ADDR, 8'h18);
    @(posedge clock_i);
    #1;
    chk({7'h00, temp_sensor_drive_o}, 8'h00, "sensor released");
    $display("test sensor done");
    // calibration conversion on the enabled sensor keeps its channel, the mux moves at once
    wr(aics_pkg::PAGE_MAIN, aics_pkg::REF_CONTROL_ADDR, 8'h04);
    chk({7'h00, temp_sensor_drive_o}, 8'h01, "sensor drives for calibration");
    @(posedge clock_i);
    conv_busy_i <= 1'b1;
    wr(aics_pkg::PAGE_MAIN, aics_pkg::INPUT_SELECT_ADDR, 8'h03);
    chk_sel(mux_sel_o, exp_sel(5'h03), "mux during conversion");
    chk_sel(sample_sel_o, exp_sel(5'h1B), "sample held");
    @(posedge clock_i);
    conv_busy_i <= 1'b0;
    @(posedge clock_i);
    #1;
    chk_sel(sample_sel_o, exp_sel(5'h03), "sample after conversion");
    $display("test conversion done");
    // offset bytes are read-only and split 9:2 and 1:0
    wr(aics_pkg::PAGE_CAL, aics_pkg::OFFSET_HIGH_ADDR, 8'h00);
    wr(aics_pkg::PAGE_CAL, aics_pkg::OFFSET_LOW_ADDR, 8'h3F);
    rd(aics_pkg::PAGE_CAL, aics_pkg::OFFSET_HIGH_ADDR);
    chk(rd_val, TRIM[9:2], "offset high");
    rd(aics_pkg::PAGE_CAL, aics_pkg::OFFSET_LOW_ADDR);
    chk(rd_val, {TRIM[1:0], 6'h00}, "offset low");
    rd(aics_pkg::PAGE_MAIN, aics_pkg::OFFSET_HIGH_ADDR);
    chk(rd_val, 8'h00, "offset absent on main page");
    $display("test offset done");
    give_verdict();
  end
endmodule
